//--- hdl/ioc_pkg.sv
// constants, types and helper functions for the three-phase
// instantaneous overcurrent block; shared by all design files
package ioc_pkg;

  localparam int unsigned CUR_W      = 16;  // current sample / rms width
  localparam int unsigned PCT_W      = 12;  // percent setting width
  localparam int unsigned PCT_EFF_W  = 13;  // percent after doubling
  localparam int unsigned PROD_W     = 29;  // rated * percent
  localparam int unsigned MEAS_W     = 23;  // measured * 100
  localparam int unsigned NPHASE     = 3;

  localparam logic [PCT_W-1:0] PCT_MIN     = 12'h014;  // 20 %
  localparam logic [PCT_W-1:0] PCT_MAX     = 12'hBB8;  // 3000 %
  localparam logic [PCT_W-1:0] PCT_DEFAULT = 12'h0C8;  // 200 %
  localparam logic [6:0]       PCT_SCALE   = 7'h64;    // 100

  // peak to rms-equivalent: 181/256 ~ 1/sqrt(2)
  localparam logic [7:0] SQRT_HALF_Q8 = 8'hB5;
  localparam int unsigned SQRT_HALF_SHIFT = 8;

  // samples per peak window, about one network period
  localparam logic [7:0] PEAK_WINDOW = 8'h14;

  typedef enum logic [1:0] {
    MODE_OFF  = 2'h0,
    MODE_PEAK = 2'h1,
    MODE_FUND = 2'h2
  } op_mode_t;

  typedef logic [CUR_W-1:0] cur_t;

  function automatic cur_t abs_mag(input cur_t s);
    abs_mag = s[CUR_W-1] ? cur_t'(~s + 16'h0001) : s;
  endfunction : abs_mag

  function automatic cur_t max_cur(input cur_t a, input cur_t b);
    max_cur = (a > b) ? a : b;
  endfunction : max_cur

endpackage : ioc_pkg

//--- hdl/phase_meas_if.sv
// carrier between the decision block and the peak selector
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface phase_meas_if;
  logic                                    sample_valid;
  logic [ioc_pkg::NPHASE-1:0][ioc_pkg::CUR_W-1:0] sample;
  logic                                    peak_valid;
  logic [ioc_pkg::NPHASE-1:0][ioc_pkg::CUR_W-1:0] peak;

  modport src  (output sample_valid, output sample,
                input  peak_valid,   input  peak);
  modport sel  (input  sample_valid, input  sample,
                output peak_valid,   output peak);
endinterface : phase_meas_if
`default_nettype wire

//--- hdl/peak_selector.sv
// per-phase peak selection over a sliding pair of windows
// assumes sample_valid pulses once per two's-complement sample
`timescale 1ns/10ps
`default_nettype none
module peak_selector (
  input  wire logic     clk_sys,
  input  wire logic     nrst,
  phase_meas_if.sel     m
);
  ioc_pkg::cur_t [ioc_pkg::NPHASE-1:0] win_max, next_win_max;
  ioc_pkg::cur_t [ioc_pkg::NPHASE-1:0] prev_max, next_prev_max;
  ioc_pkg::cur_t [ioc_pkg::NPHASE-1:0] peak, next_peak;
  logic [7:0]                          count, next_count;
  logic                                pvalid, next_pvalid;

  // the peak is the larger of this and the last window, so a fault
  // is seen at once and a cleared fault ages out within two windows
  always_comb begin
    ioc_pkg::cur_t wm;
    logic          last;
    wm            = '0;
    last          = (count == ioc_pkg::PEAK_WINDOW - 8'h01);
    next_win_max  = win_max;
    next_prev_max = prev_max;
    next_peak     = peak;
    next_count    = count;
    next_pvalid   = m.sample_valid;
    if (m.sample_valid) begin
      next_count = last ? 8'h00 : count + 8'h01;
      for (int i = 0; i < ioc_pkg::NPHASE; i++) begin
        wm = ioc_pkg::max_cur(win_max[i], ioc_pkg::abs_mag(m.sample[i]));
        next_peak[i]     = ioc_pkg::max_cur(wm, prev_max[i]);
        next_win_max[i]  = last ? '0 : wm;
        next_prev_max[i] = last ? wm : prev_max[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      win_max  <= '0;
      prev_max <= '0;
      peak     <= '0;
      count    <= 8'h00;
      pvalid   <= 1'b0;
    end else begin
      win_max  <= next_win_max;
      prev_max <= next_prev_max;
      peak     <= next_peak;
      count    <= next_count;
      pvalid   <= next_pvalid;
    end
  end

  assign m.peak       = peak;
  assign m.peak_valid = pvalid;

  property p_peak_covers_sample;
    @(posedge clk_sys) disable iff (!nrst)
    m.sample_valid |=>
      (peak[0] >= ioc_pkg::abs_mag($past(m.sample[0]))) &&
      (peak[1] >= ioc_pkg::abs_mag($past(m.sample[1]))) &&
      (peak[2] >= ioc_pkg::abs_mag($past(m.sample[2])));
  endproperty
  a_peak_covers_sample: assert property (p_peak_covers_sample)
    else $error("peak below the latest sample magnitude");

endmodule : peak_selector
`default_nettype wire

//--- hdl/inst_overcurrent_function.sv
// three-phase instantaneous overcurrent decision block
// assumes samples, rms values and settings come from logic on clk_sys;
// the fundamental rms values are computed outside and valid with
// sample_valid
// Function
// - mode off, peak or fundamental; off is default and never trips
// - start current 20..3000 percent in steps of 1, default 200
// - each phase trips at once when its quantity exceeds threshold
// - peak mode uses peaks, fundamental mode uses fundamental rms
// - a peak value is derived per phase from its own samples
// - doubling input makes the threshold twice the setting
// - block input holds every trip output low
// - general trip is formed from the three phase trips
// - general trip is the OR of the three phase trips
`timescale 1ns/10ps
`default_nettype none
module inst_overcurrent_function (
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  input  wire ioc_pkg::op_mode_t           operation_mode,
  input  wire logic [ioc_pkg::PCT_W-1:0]   start_current_threshold,
  input  wire logic [ioc_pkg::CUR_W-1:0]   rated_current,
  input  wire logic                        threshold_doubling_input,
  input  wire logic                        function_block_input,
  input  wire logic                        sample_valid,
  input  wire logic [ioc_pkg::CUR_W-1:0]   phase1_sampled_current,
  input  wire logic [ioc_pkg::CUR_W-1:0]   phase2_sampled_current,
  input  wire logic [ioc_pkg::CUR_W-1:0]   phase3_sampled_current,
  input  wire logic [ioc_pkg::CUR_W-1:0]   phase1_fundamental_rms,
  input  wire logic [ioc_pkg::CUR_W-1:0]   phase2_fundamental_rms,
  input  wire logic [ioc_pkg::CUR_W-1:0]   phase3_fundamental_rms,
  output var  logic                        phase1_trip_out,
  output var  logic                        phase2_trip_out,
  output var  logic                        phase3_trip_out,
  output var  logic                        general_trip_out
);
  phase_meas_if m ();

  ioc_pkg::cur_t [ioc_pkg::NPHASE-1:0] fund, next_fund;
  ioc_pkg::cur_t [ioc_pkg::NPHASE-1:0] selected;
  logic [ioc_pkg::NPHASE-1:0]          trip, next_trip, exceeds;
  logic                                gen, next_gen;
  logic                                enabled;
  logic [ioc_pkg::PCT_W-1:0]           pct_lim;
  logic [ioc_pkg::PCT_EFF_W-1:0]       pct_eff;
  logic [ioc_pkg::PROD_W-1:0]          thr_prod;

  function automatic logic [ioc_pkg::PCT_W-1:0] clamp_pct(
    input logic [ioc_pkg::PCT_W-1:0] p);
    if (p == '0)
      clamp_pct = ioc_pkg::PCT_DEFAULT;
    else if (p < ioc_pkg::PCT_MIN)
      clamp_pct = ioc_pkg::PCT_MIN;
    else if (p > ioc_pkg::PCT_MAX)
      clamp_pct = ioc_pkg::PCT_MAX;
    else
      clamp_pct = p;
  endfunction : clamp_pct

  assign m.sample_valid = sample_valid;
  assign m.sample       = {phase3_sampled_current,
                           phase2_sampled_current,
                           phase1_sampled_current};

  peak_selector u_peak (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .m       (m.sel)
  );

  // threshold in current units times 100, so no divider is needed
  always_comb begin
    pct_lim  = clamp_pct(start_current_threshold);
    pct_eff  = threshold_doubling_input ? {pct_lim, 1'b0}
                                        : {1'b0, pct_lim};
    thr_prod = ioc_pkg::PROD_W'(rated_current) *
               ioc_pkg::PROD_W'(pct_eff);
    enabled  = ((operation_mode == ioc_pkg::MODE_PEAK) ||
                (operation_mode == ioc_pkg::MODE_FUND)) &&
               !function_block_input;
    for (int i = 0; i < ioc_pkg::NPHASE; i++) begin
      if (operation_mode == ioc_pkg::MODE_PEAK)
        selected[i] = ioc_pkg::cur_t'((24'(m.peak[i]) *
                      24'(ioc_pkg::SQRT_HALF_Q8)) >>
                      ioc_pkg::SQRT_HALF_SHIFT);
      else
        selected[i] = fund[i];
      exceeds[i] = ioc_pkg::PROD_W'(ioc_pkg::MEAS_W'(selected[i]) *
                   ioc_pkg::MEAS_W'(ioc_pkg::PCT_SCALE)) > thr_prod;
    end
  end

  // rms values are captured with the sample so both quantities are
  // judged on the same instant when the peak arrives a cycle later
  always_comb begin
    next_fund = fund;
    if (sample_valid)
      next_fund = {phase3_fundamental_rms,
                   phase2_fundamental_rms,
                   phase1_fundamental_rms};
    next_trip = trip;
    if (!enabled)
      next_trip = '0;
    else if (m.peak_valid)
      next_trip = exceeds;
    next_gen = |next_trip;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fund <= '0;
      trip <= '0;
      gen  <= 1'b0;
    end else begin
      fund <= next_fund;
      trip <= next_trip;
      gen  <= next_gen;
    end
  end

  assign phase1_trip_out  = trip[0];
  assign phase2_trip_out  = trip[1];
  assign phase3_trip_out  = trip[2];
  assign general_trip_out = gen;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_off_no_trip;
    (operation_mode != ioc_pkg::MODE_PEAK &&
     operation_mode != ioc_pkg::MODE_FUND) |=> (trip == '0) && !gen;
  endproperty
  a_off_no_trip: assert property (p_off_no_trip)
    else $error("trip while operation is off");

  property p_pct_range;
    pct_lim >= ioc_pkg::PCT_MIN && pct_lim <= ioc_pkg::PCT_MAX;
  endproperty
  a_pct_range: assert property (p_pct_range)
    else $error("start current outside 20..3000 percent");

  property p_trip_set;
    enabled && m.peak_valid && exceeds[0] |=> phase1_trip_out;
  endproperty
  a_trip_set: assert property (p_trip_set)
    else $error("phase 1 did not trip on the next edge");

  property p_fund_select;
    operation_mode == ioc_pkg::MODE_FUND |-> selected[2] == fund[2];
  endproperty
  a_fund_select: assert property (p_fund_select)
    else $error("fundamental mode did not use the rms value");

  property p_double;
    threshold_doubling_input |->
      pct_eff == ioc_pkg::PCT_EFF_W'(2 * int'(pct_lim));
  endproperty
  a_double: assert property (p_double)
    else $error("threshold not doubled");

  property p_block;
    function_block_input ##1 function_block_input |->
      !phase1_trip_out && !phase2_trip_out && !phase3_trip_out &&
      !general_trip_out;
  endproperty
  a_block: assert property (p_block)
    else $error("trip output while blocked");

  property p_gen_needs_phase;
    general_trip_out |-> (phase1_trip_out || phase2_trip_out ||
                          phase3_trip_out);
  endproperty
  a_gen_needs_phase: assert property (p_gen_needs_phase)
    else $error("general trip without a phase trip");

  property p_gen_or;
    (phase1_trip_out || phase2_trip_out || phase3_trip_out) |->
      general_trip_out;
  endproperty
  a_gen_or: assert property (p_gen_or)
    else $error("general trip missing");

  property p_trip_clear;
    m.peak_valid && !exceeds[1] |=> !phase2_trip_out;
  endproperty
  a_trip_clear: assert property (p_trip_clear)
    else $error("phase 2 trip held below threshold");

  property p_trip_follows;
    enabled && m.peak_valid |=>
      {phase3_trip_out, phase2_trip_out, phase1_trip_out} ==
        $past(exceeds);
  endproperty
  a_trip_follows: assert property (p_trip_follows)
    else $error("phase trips differ from the evaluated comparison");

  // while enabled, between samples the trips hold; only an evaluation moves them
  property p_trip_hold;
    enabled && !m.peak_valid |=> $stable(trip);
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip changed without a new evaluation");

  property p_single;
    !threshold_doubling_input |-> pct_eff == {1'b0, pct_lim};
  endproperty
  a_single: assert property (p_single)
    else $error("threshold changed without doubling");

  property p_pct_default;
    start_current_threshold == '0 |-> pct_lim == ioc_pkg::PCT_DEFAULT;
  endproperty
  a_pct_default: assert property (p_pct_default)
    else $error("zero setting did not select the default percent");

  c_peak_trip: cover property (
    operation_mode == ioc_pkg::MODE_PEAK ##1 general_trip_out);
  c_fund_trip: cover property (
    operation_mode == ioc_pkg::MODE_FUND ##1 general_trip_out);
  c_double_trip: cover property (
    threshold_doubling_input ##1 phase3_trip_out);
  c_block_clears: cover property (
    general_trip_out ##1 function_block_input ##1 !general_trip_out);

endmodule : inst_overcurrent_function
`default_nettype wire

//--- test/frontend_model.sv
// far-side model: sampling front end and fourier stage
// assumes put is called at a falling edge of clk_sys
`timescale 1ns/10ps
`default_nettype none
module frontend_model (
  input  wire logic                clk_sys,
  output var  logic                sample_valid,
  output var  ioc_pkg::cur_t [2:0] smp,
  output var  ioc_pkg::cur_t [2:0] rms
);
  initial begin
    sample_valid = 1'b0;
    smp = '0;
    rms = '0;
  end

  // rms comes from the caller and is driven unchanged; one sample per call
  task automatic put(input ioc_pkg::cur_t [2:0] s,
                     input ioc_pkg::cur_t [2:0] r);
    sample_valid = 1'b1;
    smp = s;
    rms = r;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    // stale lines must not look valid to a careless capture
    smp = ~smp;
    rms = ~rms;
    // one idle cycle keeps two calls from writing the strobe in one step
    @(negedge clk_sys);
  endtask : put
endmodule : frontend_model
`default_nettype wire

//--- test/tb_inst_overcurrent_function.sv
// self-checking bench for the instantaneous overcurrent block
// assumes frontend_model supplies samples and fundamental rms values
`timescale 1ns/10ps
`default_nettype none
module tb_inst_overcurrent_function;
  logic                clk_sys = 1'b0;
  logic                nrst = 1'b0;
  ioc_pkg::op_mode_t   mode = ioc_pkg::MODE_OFF;
  logic [11:0]         pct = 12'h000;
  ioc_pkg::cur_t       rated = 16'h0064;
  logic                dbl = 1'b0;
  logic                blk = 1'b0;
  logic                sv;
  ioc_pkg::cur_t [2:0] smp;
  ioc_pkg::cur_t [2:0] rms;
  logic [2:0]          trip;
  logic                gen;
  logic [3:0]          expq[$];
  logic                d1 = 1'b0;
  logic                chk = 1'b0;
  int                  n_fail = 0;
  int                  num_checks = 0;
  longint              win[3];
  longint              prv[3];
  int                  cnt;
  logic [11:0]         lim[8] = '{12'h000, 12'h001, 12'h013, 12'h014,
                                  12'h015, 12'hBB7, 12'hBB8, 12'hBB9};

  always #10 clk_sys = ~clk_sys;

  frontend_model src (.clk_sys(clk_sys), .sample_valid(sv), .smp(smp),
                      .rms(rms));

  inst_overcurrent_function DUT (
    .clk_sys(clk_sys), .nrst(nrst), .operation_mode(mode),
    .start_current_threshold(pct), .rated_current(rated),
    .threshold_doubling_input(dbl), .function_block_input(blk),
    .sample_valid(sv), .phase1_sampled_current(smp[0]),
    .phase2_sampled_current(smp[1]), .phase3_sampled_current(smp[2]),
    .phase1_fundamental_rms(rms[0]), .phase2_fundamental_rms(rms[1]),
    .phase3_fundamental_rms(rms[2]), .phase1_trip_out(trip[0]),
    .phase2_trip_out(trip[1]), .phase3_trip_out(trip[2]),
    .general_trip_out(gen));

  function automatic longint eff();
    longint p;
    p = (pct == 0) ? 200 : (pct < 20) ? 20 : (pct > 3000) ? 3000 : pct;
    return dbl ? 2 * p : p;
  endfunction : eff

  task automatic check(string what, logic [3:0] exp, logic [3:0] got);
    num_checks++;
    if (exp !== got) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // note the expected trips, then hand the sample to the far side
  task automatic send(ioc_pkg::cur_t [2:0] s, ioc_pkg::cur_t [2:0] r);
    logic [3:0] e;
    longint     m;
    longint     w;
    longint     pv;
    longint     q;
    e = 4'h0;
    for (int i = 0; i < 3; i++) begin
      m = s[i][15] ? 65536 - longint'(s[i]) : longint'(s[i]);
      // peak is the larger of the running and the last closed window
      w = (m > win[i]) ? m : win[i];
      pv = (w > prv[i]) ? w : prv[i];
      if (cnt == ioc_pkg::PEAK_WINDOW - 1) begin
        prv[i] = w;
        win[i] = 0;
      end else begin
        win[i] = w;
      end
      q = (mode == ioc_pkg::MODE_PEAK) ? (pv * 181) >> 8 : r[i];
      e[i] = !blk && (mode == ioc_pkg::MODE_PEAK ||
             mode == ioc_pkg::MODE_FUND) && (q * 100 > rated * eff());
    end
    e[3] = |e[2:0];
    cnt = (cnt == ioc_pkg::PEAK_WINDOW - 1) ? 0 : cnt + 1;
    expq.push_back(e);
    src.put(s, r);
  endtask : send

  task automatic do_reset;
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    win = '{0, 0, 0};
    prv = '{0, 0, 0};
    cnt = 0;
    // the first sample waits one edge after release
    @(negedge clk_sys);
    check("reset", 4'h0, {gen, trip});
  endtask : do_reset

  always @(posedge clk_sys) begin
    d1 <= sv & nrst;
    chk <= d1 & nrst;
  end

  always @(negedge clk_sys) begin
    check("general", {3'h0, |trip}, {3'h0, gen});
    if (chk)
      check("trips", expq.pop_front(), {gen, trip});
  end

  initial begin
    #1_000_000;
    n_fail++;
    conclude();
  end

  initial begin
    ioc_pkg::cur_t [2:0] s;
    ioc_pkg::cur_t [2:0] r;
    longint              base;
    void'($urandom(32'hD73A44FE));
    @(negedge clk_sys);
    do_reset();
    // fundamental values straddle the threshold by one count
    for (int k = 0; k < 150; k++) begin
      mode = ioc_pkg::op_mode_t'((k < 8 || k % 5 < 3) ? 2 :
                                 (k % 5 == 3) ? 0 : 3);
      pct = (k < 8) ? lim[k] : 12'($urandom_range(20, 3000));
      dbl = 1'($urandom_range(0, 1));
      blk = ($urandom_range(0, 7) == 0);
      rated = 16'($urandom_range(10, 400));
      repeat (2) begin
        base = rated * eff() / 100 - 1;
        for (int i = 0; i < 3; i++) begin
          r[i] = 16'(base + $urandom_range(0, 2));
          s[i] = 16'($urandom);
        end
        send(s, r);
      end
      repeat (2) @(negedge clk_sys);
    end
    // second reset clears the peak memories
    do_reset();
    mode = ioc_pkg::MODE_PEAK;
    pct = 12'h064;
    dbl = 1'b0;
    blk = 1'b0;
    rated = 16'($urandom_range(8000, 16000));
    for (int k = 0; k < 15; k++) begin
      for (int i = 0; i < 3; i++) begin
        base = (k < 10) ? k * 3000 + $urandom_range(0, 1500) : 50;
        s[i] = ((k + i) % 2) ? 16'(-base) : 16'(base);
        r[i] = 16'($urandom);
      end
      send(s, r);
    end
    repeat (3) @(negedge clk_sys);
    check("held peak", 4'hF, {gen, trip});
    blk = 1'b1;
    @(negedge clk_sys);
    check("block drop", 4'h0, {gen, trip});
    // small samples let the held peak age out over two windows
    blk = 1'b0;
    for (int k = 0; k < 45; k++) begin
      dbl = 1'($urandom_range(0, 1));
      for (int i = 0; i < 3; i++) begin
        s[i] = 16'($urandom_range(0, 100));
        r[i] = 16'($urandom);
      end
      send(s, r);
    end
    repeat (3) @(negedge clk_sys);
    check("aged peak", 4'h0, {gen, trip});
    check("queue left", 4'h0, 4'(expq.size()));
    conclude();
  end
endmodule : tb_inst_overcurrent_function
`default_nettype wire
